// ===== design/tsq_top.sv
// Trace sample qualifier: cycle qualification and trace capture control
`timescale 1ns/10ps
module tsq_top #(
  parameter int DEPTH = tsq_pkg::TSQ_DEPTH,
  parameter int PW    = $clog2(DEPTH),
  parameter int SW    = $clog2(DEPTH + 1)
) (
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire tsq_pkg::tsq_cycle_s cyc,
  input  wire tsq_pkg::tsq_cfg_s   cfg,
  input  wire logic                run_start,
  input  wire logic                continue_run,
  input  wire logic                stop_run,
  input  wire logic [PW-1:0]       rd_addr,
  output tsq_pkg::tsq_sample_s     rd_data,
  output logic                     rd_valid,
  output logic                     running,
  output logic                     halt_req,
  output logic [PW-1:0]            wr_ptr,
  output logic [SW-1:0]            sample_count,
  output logic                     sample_stored
);
  import tsq_pkg::*;

  // ------------------------------------------------------------
  // Checks and declarations
  // ------------------------------------------------------------
  generate
    if ((DEPTH < int'(TSQ_COUNT_MAX)) || (PW != $clog2(DEPTH)) ||
        (SW != $clog2(DEPTH + 1))) begin : g_chk
      $error("tsq_top depth below largest trace count");
    end
  endgenerate

  tsq_state_e     state_r;
  tsq_state_e     state_nxt;
  tsq_cfg_s       act_r;
  tsq_cfg_s       act_nxt;
  logic [PW-1:0]  ptr_r;
  logic [PW-1:0]  ptr_nxt;
  logic [SW-1:0]  stored_r;
  logic [SW-1:0]  stored_nxt;
  logic           fseen_r;
  logic           fseen_nxt;
  logic           pulse_r;
  logic           clear;
  logic           cmd;
  logic           finite;
  logic           full;
  logic [SW-1:0]  cnt_ext;
  logic           we;
  logic           m_a;
  logic           m_d;
  logic           m_x;
  logic           i_a;
  logic           i_x;
  logic           mem_q;
  logic           io_q;
  logic           fetch_hit;
  logic           seen_eff;
  logic           split_ok;
  logic           fetch_ok;
  logic           sample_ok;
  tsq_sample_s    wsample;

  // ------------------------------------------------------------
  // Qualification
  // ------------------------------------------------------------
  tsq_match u_mem (
    .cyc           (cyc),
    .setup         (act_r.mem),
    .addr_mask     (act_r.addr_mask),
    .ext_addr_bits (act_r.ext_addr_bits),
    .use_data      (1'b1),
    .addr_ok       (m_a),
    .data_ok       (m_d),
    .ext_ok        (m_x)
  );

  // I/O cycles have no data bus compare
  tsq_match u_io (
    .cyc           (cyc),
    .setup         (act_r.io),
    .addr_mask     (act_r.addr_mask),
    .ext_addr_bits (act_r.ext_addr_bits),
    .use_data      (1'b0),
    .addr_ok       (i_a),
    .data_ok       (),
    .ext_ok        (i_x)
  );

  always_comb begin
    mem_q = cyc.is_mem && tsq_mem_qual(act_r.mem.qual, cyc);
    io_q = cyc.is_io && (act_r.io.qual == TSQ_IOQ_ANY);
    split_ok = (mem_q && m_a && m_d && m_x) || (io_q && i_a && i_x);
    fetch_hit = cyc.is_mem && cyc.is_fetch && m_a && m_x;
    // Current fetch decides for itself, others use the flag
    seen_eff = cyc.is_fetch ? fetch_hit : fseen_r;
    fetch_ok = seen_eff && (mem_q || io_q);
    sample_ok = (act_r.trace_mode == TSQ_MODE_FETCH) ? fetch_ok
                                                      : split_ok;
  end

  // ------------------------------------------------------------
  // Capture control
  // ------------------------------------------------------------
  always_comb begin
    cmd     = run_start || continue_run || stop_run;
    finite  = act_r.trace_count != TSQ_COUNT_INF;
    cnt_ext = {{(SW - TSQ_CNT_W){1'b0}}, act_r.trace_count};
    full    = finite && (stored_r >= cnt_ext);
    // Commands take priority, so no sample lands mid-reload
    we = (state_r == TSQ_RUN) && !cmd && cyc.valid && sample_ok && !full;
    wsample.is_io    = cyc.is_io;
    wsample.is_read  = cyc.is_read;
    wsample.is_write = cyc.is_write;
    wsample.is_fetch = cyc.is_fetch;
    wsample.addr     = cyc.addr;
    wsample.data     = cyc.data;
    wsample.ext      = cyc.ext;
  end

  always_comb begin
    state_nxt  = state_r;
    act_nxt    = act_r;
    ptr_nxt    = ptr_r;
    stored_nxt = stored_r;
    fseen_nxt  = fseen_r;
    clear      = 1'b0;
    if (run_start) begin
      act_nxt    = cfg;
      clear      = 1'b1;
      ptr_nxt    = '0;
      stored_nxt = '0;
      fseen_nxt  = 1'b0;
      state_nxt  = TSQ_RUN;
    end else if (continue_run) begin
      act_nxt = cfg;
      if (cfg.trace_count != act_r.trace_count) begin
        clear      = 1'b1;
        ptr_nxt    = '0;
        stored_nxt = '0;
        fseen_nxt  = 1'b0;
      end
      state_nxt = TSQ_RUN;
    end else if (stop_run) begin
      state_nxt = TSQ_IDLE;
    end else begin
      case (state_r)
        TSQ_IDLE: begin
          state_nxt = TSQ_IDLE;
        end
        TSQ_RUN: begin
          if (we) begin
            ptr_nxt = ptr_r + PW'(1);
            if (ptr_r == PW'(DEPTH - 1)) begin
              ptr_nxt = '0;
            end
            if (stored_r != SW'(DEPTH)) begin
              stored_nxt = stored_r + SW'(1);
            end
          end
          if (cyc.valid && cyc.is_fetch) begin
            fseen_nxt = fetch_hit;
          end
          if (finite && (stored_nxt >= cnt_ext)) begin
            state_nxt = TSQ_HALT;
          end
        end
        TSQ_HALT: begin
          state_nxt = TSQ_HALT;
        end
        default: begin
          state_nxt = TSQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r  <= TSQ_IDLE;
      act_r    <= TSQ_CFG_RST;
      ptr_r    <= '0;
      stored_r <= '0;
      fseen_r  <= 1'b0;
      pulse_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      act_r    <= act_nxt;
      ptr_r    <= ptr_nxt;
      stored_r <= stored_nxt;
      fseen_r  <= fseen_nxt;
      pulse_r  <= we;
    end
  end

  // ------------------------------------------------------------
  // Sample store
  // ------------------------------------------------------------
  tsq_buffer #(
    .DEPTH (DEPTH),
    .WIDTH ($bits(tsq_sample_s)),
    .PW    (PW)
  ) u_buf (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .clear   (clear),
    .we      (we),
    .waddr   (ptr_r),
    .wdata   (wsample),
    .raddr   (rd_addr),
    .rdata   (rd_data),
    .rvalid  (rd_valid)
  );

  assign running       = state_r == TSQ_RUN;
  assign halt_req      = state_r == TSQ_HALT;
  assign wr_ptr        = ptr_r;
  assign sample_count  = stored_r;
  assign sample_stored = pulse_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  logic quiet;
  assign quiet = !cmd;

  a_finite_halt: assert property (
    we && finite && (stored_r + SW'(1) == cnt_ext) ##1 quiet
    |-> halt_req && (sample_count == $past(cnt_ext)))
    else $error("no halt after last sample");

  a_inf_no_halt: assert property (
    running && !finite && quiet |=> !halt_req)
    else $error("halt with infinite trace count");

  a_wrap_zero: assert property (
    we && (ptr_r == PW'(DEPTH - 1)) |=> wr_ptr == '0)
    else $error("pointer did not wrap");

  a_run_clears: assert property (
    run_start |=> (wr_ptr == '0) && (sample_count == '0) && running
                  && (act_r == $past(cfg)))
    else $error("run did not reload and clear");

  a_cont_keeps: assert property (
    continue_run && !run_start && (cfg.trace_count == act_r.trace_count)
    |=> $stable(wr_ptr) && $stable(sample_count) && running)
    else $error("continue lost history");

  a_mem_off: assert property (
    (act_r.trace_mode == TSQ_MODE_SPLIT) && (act_r.mem.qual == TSQ_MQ_OFF)
    && cyc.is_mem && !cyc.is_io |-> !sample_ok)
    else $error("memory cycle taken with qualifier off");

  a_write_only: assert property (
    (act_r.trace_mode == TSQ_MODE_SPLIT) && (act_r.mem.qual == TSQ_MQ_WR)
    && cyc.is_mem && !cyc.is_write && !cyc.is_io |-> !sample_ok)
    else $error("non-write taken with write qualifier");

  a_data_gate: assert property (
    (act_r.trace_mode == TSQ_MODE_SPLIT) && !cyc.is_io &&
    !tsq_masked_eq(cyc.data, act_r.mem.data_cmp, act_r.mem.data_mask)
    |-> !we)
    else $error("sample stored with data mismatch");

  a_ptr_step: assert property (
    we && (ptr_r != PW'(DEPTH - 1))
    |=> (wr_ptr == $past(ptr_r) + PW'(1)) && sample_stored)
    else $error("pointer did not advance by one");

  c_wrap: cover property (we && (ptr_r == PW'(DEPTH - 1)));
  c_halt: cover property (running ##1 halt_req);
  c_fetch_mode: cover property (we && act_r.trace_mode == TSQ_MODE_FETCH);
  c_continue: cover property (halt_req ##1 continue_run);
endmodule

// ===== design/tsq_pkg.sv
// Shared types and constants for the trace sample qualifier
package tsq_pkg;
  localparam int          TSQ_AW        = 16;
  localparam int          TSQ_DW        = 16;
  localparam int          TSQ_XW        = 8;
  localparam int          TSQ_CNT_W     = 11;
  localparam int          TSQ_DEPTH     = 2048;
  localparam logic [10:0] TSQ_COUNT_MAX = 11'h7FF;
  localparam logic [10:0] TSQ_COUNT_INF = 11'h000;
  localparam logic [15:0] TSQ_AMASK_RST = 16'hFFFF;
  localparam logic [2:0]  TSQ_MQ_OFF    = 3'h0;
  localparam logic [2:0]  TSQ_MQ_ANY    = 3'h1;
  localparam logic [2:0]  TSQ_MQ_RD     = 3'h2;
  localparam logic [2:0]  TSQ_MQ_WR     = 3'h3;
  localparam logic [2:0]  TSQ_MQ_FETCH  = 3'h4;
  localparam logic [2:0]  TSQ_IOQ_ANY   = 3'h1;
  localparam logic        TSQ_MODE_SPLIT = 1'b0;
  localparam logic        TSQ_MODE_FETCH = 1'b1;

  typedef enum logic [1:0] {TSQ_IDLE, TSQ_RUN, TSQ_HALT} tsq_state_e;

  typedef struct packed {
    logic              valid;
    logic              is_mem;
    logic              is_io;
    logic              is_read;
    logic              is_write;
    logic              is_fetch;
    logic [TSQ_AW-1:0] addr;
    logic [TSQ_DW-1:0] data;
    logic [TSQ_XW-1:0] ext;
  } tsq_cycle_s;

  typedef struct packed {
    logic [2:0]        qual;
    logic [TSQ_AW-1:0] addr1;
    logic [TSQ_AW-1:0] addr2;
    logic              range_on;
    logic [TSQ_DW-1:0] data_cmp;
    logic [TSQ_DW-1:0] data_mask;
    logic [TSQ_XW-1:0] ext_cmp;
    logic [TSQ_XW-1:0] ext_mask;
    logic [TSQ_XW-1:0] ext_addr_cmp;
  } tsq_setup_s;

  typedef struct packed {
    logic [TSQ_CNT_W-1:0] trace_count;
    logic [TSQ_AW-1:0]    addr_mask;
    logic                 trace_mode;
    logic [3:0]           ext_addr_bits;
    tsq_setup_s           mem;
    tsq_setup_s           io;
  } tsq_cfg_s;

  typedef struct packed {
    logic              is_io;
    logic              is_read;
    logic              is_write;
    logic              is_fetch;
    logic [TSQ_AW-1:0] addr;
    logic [TSQ_DW-1:0] data;
    logic [TSQ_XW-1:0] ext;
  } tsq_sample_s;

  localparam tsq_cfg_s TSQ_CFG_RST = tsq_cfg_s'({TSQ_COUNT_INF,
    TSQ_AMASK_RST, {($bits(tsq_cfg_s) - 27){1'b0}}});

  function automatic logic tsq_masked_eq(input logic [15:0] v,
                                         input logic [15:0] c,
                                         input logic [15:0] m);
    tsq_masked_eq = ((v ^ c) & m) == 16'h0000;
  endfunction

  function automatic logic tsq_mem_qual(input logic [2:0] q,
                                        input tsq_cycle_s c);
    case (q)
      TSQ_MQ_ANY:   tsq_mem_qual = c.is_read | c.is_write | c.is_fetch;
      TSQ_MQ_RD:    tsq_mem_qual = c.is_read | c.is_fetch;
      TSQ_MQ_WR:    tsq_mem_qual = c.is_write;
      TSQ_MQ_FETCH: tsq_mem_qual = c.is_fetch;
      default:      tsq_mem_qual = 1'b0;
    endcase
  endfunction
endpackage

// ===== design/tsq_match.sv
// Address, data bus and probe byte qualification for one setup
`timescale 1ns/10ps
module tsq_match (
  input  wire tsq_pkg::tsq_cycle_s cyc,
  input  wire tsq_pkg::tsq_setup_s setup,
  input  wire logic [15:0]         addr_mask,
  input  wire logic [3:0]          ext_addr_bits,
  input  wire logic                use_data,
  output logic                     addr_ok,
  output logic                     data_ok,
  output logic                     ext_ok
);
  import tsq_pkg::*;

  logic        excl;
  logic [15:0] ma;
  logic [15:0] m1;
  logic [15:0] m2;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [7:0]  dfield;

  always_comb begin
    excl = setup.addr1 > setup.addr2;
    ma = cyc.addr & addr_mask;
    m1 = setup.addr1 & addr_mask;
    m2 = setup.addr2 & addr_mask;
    // Masking can reorder the bounds, so sort them again
    lo = (m1 > m2) ? m2 : m1;
    hi = (m1 > m2) ? m1 : m2;
    if (!setup.range_on) begin
      addr_ok = (ma == m1) || (ma == m2);
    end else if (excl) begin
      addr_ok = !((ma > lo) && (ma < hi));
    end else begin
      addr_ok = (ma >= lo) && (ma <= hi);
    end
    dfield = 8'hFF >> ext_addr_bits;
    data_ok = !use_data ||
              tsq_masked_eq(cyc.data, setup.data_cmp, setup.data_mask);
    ext_ok = tsq_masked_eq({8'h00, cyc.ext}, {8'h00, setup.ext_cmp},
                           {8'h00, setup.ext_mask & dfield}) &&
             tsq_masked_eq({8'h00, cyc.ext}, {8'h00, setup.ext_addr_cmp},
                           {8'h00, ~dfield});
  end
endmodule

// ===== design/tsq_buffer.sv
// Trace sample store with per-location valid bits
`timescale 1ns/10ps
module tsq_buffer #(
  parameter int DEPTH = 2048,
  parameter int WIDTH = 44,
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             clear,
  input  wire logic             we,
  input  wire logic [PW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [PW-1:0]    raddr,
  output logic [WIDTH-1:0]      rdata,
  output logic                  rvalid
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_r;
  logic [DEPTH-1:0] valid_nxt;
  logic [WIDTH-1:0] rdata_r;
  logic             rvalid_r;

  generate
    if ((DEPTH < 2) || (PW < $clog2(DEPTH))) begin : g_chk
      $error("tsq_buffer needs at least two locations");
    end
  endgenerate

  // Clearing valid bits avoids a long wipe of the array
  always_comb begin
    valid_nxt = valid_r;
    if (clear) begin
      valid_nxt = '0;
    end else if (we) begin
      valid_nxt[waddr] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      valid_r  <= '0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      valid_r  <= valid_nxt;
      rdata_r  <= mem[raddr];
      rvalid_r <= valid_r[raddr];
    end
  end

  assign rdata  = rdata_r;
  assign rvalid = rvalid_r;
endmodule

// ===== verification/tsq_bus_model.sv
// Target bus model: one cycle per request, scrambled lines when idle
`timescale 1ns/10ps
module tsq_bus_model (
  input  wire logic                sys_clk,
  input  wire logic                go,
  input  wire tsq_pkg::tsq_cycle_s req,
  output tsq_pkg::tsq_cycle_s      cyc
);
  import tsq_pkg::*;
  tsq_cycle_s last_r = '0;
  always_ff @(posedge sys_clk) begin
    if (go) begin
      last_r <= req;
    end
  end
  // Idle lines invert, so a stale value never looks like a real cycle
  always_comb begin
    cyc = '0;
    if (go) begin
      cyc = req;
    end else begin
      cyc.addr = ~last_r.addr;
      cyc.data = ~last_r.data;
      cyc.ext  = ~last_r.ext;
    end
  end
endmodule

// ===== verification/tsq_top_test.sv
// Self-checking bench for the trace sample qualifier
`timescale 1ns/10ps
module tsq_top_test;
  import tsq_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        go = 1'b0;
  tsq_cycle_s  req = '0;
  tsq_cycle_s  cyc;
  tsq_cfg_s    cfg = TSQ_CFG_RST;
  tsq_cfg_s    c;
  logic        run_start = 1'b0;
  logic        continue_run = 1'b0;
  logic        stop_run = 1'b0;
  logic [10:0] rd_addr = '0;
  tsq_sample_s rd_data;
  logic        rd_valid;
  logic        running;
  logic        halt_req;
  logic [10:0] wr_ptr;
  logic [11:0] sample_count;
  logic        sample_stored;
  int          bad_count = 0;
  int          cmp_count = 0;
  logic [2:0]  qtab [5] = '{3'b000, 3'b111, 3'b101, 3'b010, 3'b001};

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  tsq_bus_model u_bus (.sys_clk(sys_clk), .go(go), .req(req), .cyc(cyc));

  tsq_top u_dut (
    .sys_clk      (sys_clk),
    .resetn       (resetn),
    .cyc          (cyc),
    .cfg          (cfg),
    .run_start    (run_start),
    .continue_run (continue_run),
    .stop_run     (stop_run),
    .rd_addr      (rd_addr),
    .rd_data      (rd_data),
    .rd_valid     (rd_valid),
    .running      (running),
    .halt_req     (halt_req),
    .wr_ptr       (wr_ptr),
    .sample_count (sample_count),
    .sample_stored(sample_stored)
  );

  task automatic chk(input string m, input logic [15:0] g,
                     input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic tsq_cycle_s mk(input int k, input logic [15:0] a,
                                    input logic [15:0] d,
                                    input logic [7:0] x);
    mk = '0;
    mk.valid = 1'b1;
    mk.is_mem = (k != 3);
    mk.is_io = (k == 3);
    mk.is_read = (k == 0 || k == 3);
    mk.is_write = (k == 1);
    mk.is_fetch = (k == 2);
    mk.addr = a;
    mk.data = d;
    mk.ext = x;
  endfunction

  function automatic tsq_cfg_s base();
    base = TSQ_CFG_RST;
    base.mem.qual = TSQ_MQ_ANY;
    base.mem.addr1 = 16'h0100;
    base.mem.addr2 = 16'h0100;
  endfunction

  // Command pulse: 0 fresh run, 1 continue, 2 stop
  task automatic cmd(input int w, input tsq_cfg_s n);
    @(posedge sys_clk);
    cfg <= n;
    run_start <= (w == 0);
    continue_run <= (w == 1);
    stop_run <= (w == 2);
    @(posedge sys_clk);
    run_start <= 1'b0;
    continue_run <= 1'b0;
    stop_run <= 1'b0;
    #1;
  endtask

  task automatic bus(input int k, input logic [15:0] a,
                     input logic [15:0] d, input logic [7:0] x,
                     input logic e);
    @(posedge sys_clk);
    go <= 1'b1;
    req <= mk(k, a, d, x);
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
    chk("stored", sample_stored, e);
  endtask

  // Back-to-back writes at the base address, data carries the index
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      go <= 1'b1;
      req <= mk(1, 16'h0100, i[15:0], 8'h00);
    end
    @(posedge sys_clk);
    go <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [10:0] a);
    @(posedge sys_clk);
    rd_addr <= a;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk("run", running, 1'b0);
    chk("cnt", sample_count, 16'h0);
    for (int q = 0; q < 5; q++) begin
      c = base();
      c.mem.qual = q[2:0];
      cmd(0, c);
      for (int k = 0; k < 3; k++) begin
        bus(k, 16'h0100, 16'h0, 8'h0, qtab[q][2-k]);
      end
    end
    c = base();
    c.io.addr1 = 16'h0050;
    c.io.addr2 = 16'h0050;
    cmd(0, c);
    bus(3, 16'h0050, 16'h0, 8'h0, 1'b0);
    c.io.qual = TSQ_IOQ_ANY;
    cmd(0, c);
    bus(3, 16'h0050, 16'h0, 8'h0, 1'b1);
    bus(3, 16'h0051, 16'h0, 8'h0, 1'b0);
    c = base();
    c.mem.addr2 = 16'h0200;
    cmd(0, c);
    bus(0, 16'h0200, 16'h0, 8'h0, 1'b1);
    bus(0, 16'h0150, 16'h0, 8'h0, 1'b0);
    c.mem.range_on = 1'b1;
    cmd(0, c);
    bus(0, 16'h0150, 16'h0, 8'h0, 1'b1);
    bus(0, 16'h0201, 16'h0, 8'h0, 1'b0);
    c.mem.addr1 = 16'h0200;
    c.mem.addr2 = 16'h0100;
    cmd(0, c);
    bus(0, 16'h0150, 16'h0, 8'h0, 1'b0);
    bus(0, 16'h0300, 16'h0, 8'h0, 1'b1);
    c.mem.addr1 = 16'h0000;
    c.mem.addr2 = 16'h0080;
    c.addr_mask = 16'h3FFF;
    cmd(0, c);
    bus(0, 16'hC080, 16'h0, 8'h0, 1'b1);
    bus(0, 16'h4081, 16'h0, 8'h0, 1'b0);
    c.mem.addr1 = 16'hC010;
    c.mem.addr2 = 16'h0020;
    cmd(0, c);
    bus(0, 16'h4018, 16'h0, 8'h0, 1'b0);
    bus(0, 16'h4030, 16'h0, 8'h0, 1'b1);
    c = base();
    c.mem.data_cmp = 16'h001A;
    c.mem.data_mask = 16'hFFF0;
    cmd(0, c);
    bus(0, 16'h0100, 16'h001F, 8'h0, 1'b1);
    bus(0, 16'h0100, 16'h002A, 8'h0, 1'b0);
    c.mem.data_mask = 16'hFFFF;
    cmd(0, c);
    bus(0, 16'h0100, 16'h001A, 8'h0, 1'b1);
    bus(0, 16'h0100, 16'h001B, 8'h0, 1'b0);
    c = base();
    c.mem.ext_cmp = 8'hA5;
    c.mem.ext_mask = 8'hFF;
    cmd(0, c);
    bus(0, 16'h0100, 16'h0, 8'hA5, 1'b1);
    bus(0, 16'h0100, 16'h0, 8'h25, 1'b0);
    c.ext_addr_bits = 4'h4;
    c.mem.ext_addr_cmp = 8'h55;
    c.mem.ext_cmp = 8'h03;
    c.mem.ext_mask = 8'h0F;
    cmd(0, c);
    bus(0, 16'h0100, 16'h0, 8'h53, 1'b1);
    bus(0, 16'h0100, 16'h0, 8'h54, 1'b0);
    bus(0, 16'h0100, 16'h0, 8'h63, 1'b0);
    c.mem.ext_cmp = 8'h00;
    c.mem.ext_mask = 8'hF0;
    cmd(0, c);
    bus(0, 16'h0100, 16'h0, 8'h57, 1'b1);
    c = base();
    c.trace_mode = TSQ_MODE_FETCH;
    c.mem.addr1 = 16'h0200;
    c.mem.addr2 = 16'h0200;
    cmd(0, c);
    bus(1, 16'h0300, 16'h0, 8'h0, 1'b0);
    bus(2, 16'h0200, 16'h0, 8'h0, 1'b1);
    bus(1, 16'h0300, 16'h0, 8'h0, 1'b1);
    bus(2, 16'h0400, 16'h0, 8'h0, 1'b0);
    bus(1, 16'h0300, 16'h0, 8'h0, 1'b0);
    c = base();
    c.trace_count = 11'h003;
    cmd(0, c);
    burst(4);
    chk("cnt", sample_count, 16'h3);
    chk("ptr", wr_ptr, 16'h3);
    chk("halt", halt_req, 1'b1);
    chk("run", running, 1'b0);
    rd(11'h001);
    chk("rdat", rd_data.data, 16'h1);
    chk("radr", rd_data.addr, 16'h0100);
    chk("rtyp", rd_data.is_write, 1'b1);
    chk("rvld", rd_valid, 1'b1);
    c.mem.addr1 = 16'h0000;
    cmd(1, c);
    chk("keep", sample_count, 16'h3);
    c.trace_count = 11'h005;
    cmd(1, c);
    chk("clr", sample_count, 16'h0);
    chk("run", running, 1'b1);
    cmd(2, c);
    chk("stop", running, 1'b0);
    c = base();
    cmd(0, c);
    burst(2049);
    chk("wrap", wr_ptr, 16'h1);
    chk("cnt", sample_count, 16'h0800);
    chk("halt", halt_req, 1'b0);
    chk("run", running, 1'b1);
    rd(11'h000);
    chk("over", rd_data.data, 16'h0800);
    cmd(0, c);
    chk("cnt", sample_count, 16'h0);
    chk("ptr", wr_ptr, 16'h0);
    rd(11'h005);
    chk("vld", rd_valid, 1'b0);
    summarize();
  end
endmodule
